// [logic/crcs_engine.sv]
// Bit-serial shifter and accumulator of the CRC engine
`timescale 1ns/100ps
`default_nettype none

module crcs_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic kill_i,
    input wire logic halt_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [31:0] word_i,
    input wire logic [4:0] data_length_field_i,
    input wire logic [4:0] poly_length_field_i,
    input wire logic [31:0] poly_i,
    input wire logic augment_i,
    input wire logic lsb_first_i,
    input wire logic seed_we_i,
    input wire logic [1:0] seed_lane_i,
    input wire logic [7:0] seed_byte_i,
    output logic [31:0] acc_o,
    output logic [31:0] shift_o,
    output logic shifting_o
);

    logic [31:0] acc_r;
    logic [31:0] sh_r;
    logic [4:0] cnt_r;
    logic act_r;

    // One division step; augmented mode folds the data bit into the feedback
    function automatic logic [31:0] crc_step(input logic [31:0] acc, input logic din,
                                             input logic [4:0] poly_length_field, input logic [31:0] poly,
                                             input logic aug);
        logic [31:0] mask;
        logic [31:0] nx;
        logic fb;
        mask = 32'hffffffff >> (5'd31 - poly_length_field);
        fb = acc[poly_length_field] ^ (aug & din);
        nx = ((acc << 1) | {31'h0, ~aug & din}) & mask;
        if (fb) begin
            nx = nx ^ ((poly | 32'h00000001) & mask);
        end
        return nx;
    endfunction : crc_step

    wire logic din = lsb_first_i ? sh_r[0] : sh_r[31];
    wire logic [31:0] acc_step = crc_step(acc_r, din, poly_length_field_i, poly_i, augment_i);
    wire logic [31:0] sh_step = lsb_first_i ? (sh_r >> 1) : (sh_r << 1);
    wire logic [31:0] sh_load = lsb_first_i ? word_i : (word_i << (5'd31 - data_length_field_i));
    wire logic stepping = act_r & run_i;

    always_ff @(posedge clk_i) begin
        if (rst_i || kill_i) begin
            act_r <= 1'b0;
            cnt_r <= 5'h00;
            sh_r <= 32'h0;
        end else if (ce_i) begin
            if (halt_i) begin
                act_r <= 1'b0;
                sh_r <= 32'h0;
            end else if (load_i && !act_r) begin
                act_r <= 1'b1;
                cnt_r <= data_length_field_i;
                sh_r <= sh_load;
            end else if (stepping) begin
                sh_r <= sh_step;
                cnt_r <= cnt_r - 5'h01;
                act_r <= (cnt_r != 5'h00);
            end
        end
    end

    // Seed writes win over a step in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || kill_i) begin
            acc_r <= 32'h0;
        end else if (ce_i) begin
            if (seed_we_i) begin
                acc_r <= crcs_pkg::put_byte(acc_r, seed_lane_i, seed_byte_i);
            end else if (stepping && !halt_i) begin
                acc_r <= acc_step;
            end
        end
    end

    assign acc_o = acc_r;
    assign shift_o = sh_r;
    assign shifting_o = act_r;

    load_count_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        load_i && !act_r && !halt_i && !kill_i |=> act_r && cnt_r == $past(data_length_field_i))
        else $error("shifter not loaded with data length");

    last_bit_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        act_r && run_i && cnt_r == 5'h00 && !halt_i && !kill_i |=> !act_r)
        else $error("shifter kept running past last bit");

    run_hold_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        act_r && !run_i && !halt_i && !kill_i && !seed_we_i |=> $stable(acc_r) && $stable(sh_r))
        else $error("shifter moved with run bit clear");

endmodule : crcs_engine

`default_nettype wire

// [logic/crcs_pkg.sv]
// Constants, register map and byte helpers shared by the CRC scanner design
package crcs_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [9:0] IDX_DATA = 10'h34e;
    localparam logic [9:0] IDX_OVL = 10'h352;
    localparam logic [9:0] IDX_CON0 = 10'h356;
    localparam logic [9:0] IDX_CON1 = 10'h357;
    localparam logic [9:0] IDX_CON2 = 10'h358;
    localparam logic [9:0] IDX_SCON = 10'h360;
    localparam logic [9:0] IDX_SLO = 10'h361;
    localparam logic [9:0] IDX_SHI = 10'h364;
    localparam logic [9:0] IDX_TSEL = 10'h367;
    localparam logic [9:0] IDX_SSTAT = 10'h368;
    localparam logic [9:0] IDX_PMD = 10'h369;
    localparam logic [9:0] WORD_BYTES = 10'h004;
    localparam logic [9:0] ADDR_BYTES = 10'h003;

    // Control register 0 fields
    localparam int CON0_EN = 7;
    localparam int CON0_GO = 6;
    localparam int CON0_BUSY = 5;
    localparam int CON0_AUGMENT_ZEROS_BIT = 4;
    localparam int CON0_SETUP = 2;
    localparam int CON0_BIT_ORDER_SELECT = 1;
    localparam int CON0_FULL = 0;
    localparam logic [7:0] CON0_RST = 8'h00;

    // Overlay select codes; other codes reach the result
    localparam logic [1:0] OVL_POLY = 2'b10;
    localparam logic [1:0] OVL_SHIFT = 2'b01;

    // Scanner control, status and module-off fields
    localparam int SCON_EN = 7;
    localparam int SCON_RUN = 6;
    localparam int SCON_BURST = 5;
    localparam int SCON_MEMORY_REGION_SELECT = 4;
    localparam int SCON_TRIG = 3;
    localparam int SSTAT_DONE = 0;
    localparam int SSTAT_IE = 1;
    localparam int PMD_CRC = 0;
    localparam int PMD_SCAN = 1;

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[{lane, 3'b000} +: 8] = b;
        return r;
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
        return w[{lane, 3'b000} +: 8];
    endfunction : get_byte

endpackage : crcs_pkg

// [logic/crcs_scanner.sv]
// CRC engine registers, data path handshake and memory scanner
`timescale 1ns/100ps
`default_nettype none

module crcs_scanner #(
    parameter int ADDR_W = 24,
    parameter int TRIG_N = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_req_o,
    output logic mem_lock_o,
    output logic mem_region_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_grant_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic [TRIG_N-1:0] trig_i,
    input wire logic scanner_fuse_i,
    output logic scan_irq_o
);

    localparam int TSEL_W = (TRIG_N > 1) ? $clog2(TRIG_N) : 1;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic ack_r;
    logic [31:0] rdat_r;
    logic en_r;
    logic go_r;
    logic augment_zeros_bit_r;
    logic [1:0] setup_r;
    logic bit_order_select_r;
    logic full_r;
    logic [4:0] poly_length_field_r;
    logic [4:0] data_length_field_r;
    logic [31:0] data_r;
    logic [31:0] poly_r;
    logic sen_r;
    logic srun_r;
    logic burst_r;
    logic memory_region_select_r;
    logic scan_trigger_enable_r;
    logic [ADDR_W-1:0] slo_r;
    logic [ADDR_W-1:0] shi_r;
    logic [7:0] tsel_r;
    logic done_r;
    logic ie_r;
    logic crc_off_r;
    logic scan_off_r;
    logic req_r;
    logic lock_r;
    logic irq_r;
    logic [31:0] acc_w;
    logic [31:0] shift_w;
    logic shifting_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire logic [9:0] idx = wb_adr_i[11:2];
    wire logic [7:0] wbyte = wb_dat_i[7:0];
    wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
    wire logic rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
    wire logic crc_on = ~crc_off_r;
    wire logic wr_crc = wr & crc_on;
    wire logic [9:0] d_off = idx - crcs_pkg::IDX_DATA;
    wire logic [9:0] o_off = idx - crcs_pkg::IDX_OVL;
    wire logic [9:0] l_off = idx - crcs_pkg::IDX_SLO;
    wire logic [9:0] h_off = idx - crcs_pkg::IDX_SHI;
    wire logic hit_d = d_off < crcs_pkg::WORD_BYTES;
    wire logic hit_o = o_off < crcs_pkg::WORD_BYTES;
    wire logic hit_l = l_off < crcs_pkg::ADDR_BYTES;
    wire logic hit_h = h_off < crcs_pkg::ADDR_BYTES;
    wire logic wr_con0 = wr_crc & (idx == crcs_pkg::IDX_CON0);
    wire logic wr_scon = wr & (idx == crcs_pkg::IDX_SCON);
    wire logic wr_sstat = wr & (idx == crcs_pkg::IDX_SSTAT);
    wire logic wr_low = wr_crc & (idx == crcs_pkg::IDX_DATA);
    wire logic ovl_poly = (setup_r == crcs_pkg::OVL_POLY);
    wire logic ovl_shift = (setup_r == crcs_pkg::OVL_SHIFT);
    wire logic wr_poly = wr_crc & hit_o & ovl_poly;
    wire logic wr_seed = wr_crc & hit_o & ~ovl_poly & ~ovl_shift;

    ////////////////////////////////////////////////////////////////////////////////
    // Data path and scanner control

    wire logic busy = full_r | shifting_w;
    wire logic halt = ~en_r;
    wire logic xfer = full_r & go_r & en_r & ~shifting_w & crc_on;
    // Scanner available only with fuse set and scanner off clear
    wire logic scan_avail = scanner_fuse_i & ~scan_off_r;
    wire logic scan_act = srun_r & sen_r & en_r & go_r & scan_avail & crc_on;
    wire logic trig_hit = trig_i[tsel_r[TSEL_W-1:0]];
    // Fetch only into an empty input
    wire logic can_take = ~full_r & (~scan_trigger_enable_r | trig_hit);
    wire logic req_nxt = scan_act & (burst_r | can_take);
    wire logic lock_nxt = scan_act & burst_r;
    wire logic fetch = req_r & mem_grant_i & scan_act & can_take;
    wire logic last = (slo_r == shi_r);
    wire logic [31:0] slo_wide = 32'(slo_r);
    wire logic [31:0] shi_wide = 32'(shi_r);
    wire logic [31:0] slo_put = crcs_pkg::put_byte(slo_wide, l_off[1:0], wbyte);
    wire logic [31:0] shi_put = crcs_pkg::put_byte(shi_wide, h_off[1:0], wbyte);

    wire logic srun_nxt = (~en_r | ~scan_avail | crc_off_r) ? 1'b0 :
                          (fetch & last) ? 1'b0 :
                          wr_scon ? wbyte[crcs_pkg::SCON_RUN] : srun_r;
    wire logic srun_fall = srun_r & ~srun_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    wire logic [31:0] ovl_word = ovl_poly ? (poly_r | 32'h00000001) :
                                 ovl_shift ? shift_w : acc_w;
    wire logic [7:0] con0_v = {en_r, go_r, busy, augment_zeros_bit_r, setup_r, bit_order_select_r, full_r};
    wire logic [7:0] scon_v = {sen_r, srun_r, burst_r, memory_region_select_r, scan_trigger_enable_r, 3'b000};
    wire logic [7:0] rd_byte =
        hit_d ? crcs_pkg::get_byte(data_r, d_off[1:0]) :
        hit_o ? crcs_pkg::get_byte(ovl_word, o_off[1:0]) :
        (idx == crcs_pkg::IDX_CON0) ? con0_v :
        (idx == crcs_pkg::IDX_CON1) ? {3'b000, poly_length_field_r} :
        (idx == crcs_pkg::IDX_CON2) ? {3'b000, data_length_field_r} :
        (idx == crcs_pkg::IDX_SCON) ? scon_v :
        hit_l ? crcs_pkg::get_byte(slo_wide, l_off[1:0]) :
        hit_h ? crcs_pkg::get_byte(shi_wide, h_off[1:0]) :
        (idx == crcs_pkg::IDX_TSEL) ? tsel_r :
        (idx == crcs_pkg::IDX_SSTAT) ? {6'h00, ie_r, done_r} :
        (idx == crcs_pkg::IDX_PMD) ? {6'h00, scan_off_r, crc_off_r} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone answer

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end else if (ce_i) begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            if (rd) begin
                rdat_r <= {24'h000000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CRC configuration

    // Module off returns CRC to reset
    always_ff @(posedge clk_i) begin
        if (rst_i || crc_off_r) begin
            {en_r, go_r, augment_zeros_bit_r, setup_r, bit_order_select_r} <= crcs_pkg::CON0_RST[7:2];
        end else if (ce_i && wr_con0) begin
            en_r <= wbyte[crcs_pkg::CON0_EN];
            go_r <= wbyte[crcs_pkg::CON0_GO];
            augment_zeros_bit_r <= wbyte[crcs_pkg::CON0_AUGMENT_ZEROS_BIT];
            setup_r <= wbyte[crcs_pkg::CON0_SETUP +: 2];
            bit_order_select_r <= wbyte[crcs_pkg::CON0_BIT_ORDER_SELECT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || crc_off_r) begin
            poly_length_field_r <= 5'h00;
            data_length_field_r <= 5'h00;
            poly_r <= 32'h0;
        end else if (ce_i) begin
            if (wr_crc && idx == crcs_pkg::IDX_CON1) begin
                poly_length_field_r <= wbyte[4:0];
            end
            if (wr_crc && idx == crcs_pkg::IDX_CON2) begin
                data_length_field_r <= wbyte[4:0];
            end
            if (wr_poly) begin
                poly_r <= crcs_pkg::put_byte(poly_r, o_off[1:0], wbyte);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data input and pending flag

    // New word sets pending; move clears it
    always_ff @(posedge clk_i) begin
        if (rst_i || crc_off_r) begin
            data_r <= 32'h0;
            full_r <= 1'b0;
        end else if (ce_i) begin
            if (fetch) begin
                data_r <= mem_rdata_i;
            end else if (wr_crc && hit_d) begin
                data_r <= crcs_pkg::put_byte(data_r, d_off[1:0], wbyte);
            end
            if (fetch || wr_low) begin
                full_r <= 1'b1;
            end else if (xfer || halt) begin
                full_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scanner registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {sen_r, burst_r, memory_region_select_r, scan_trigger_enable_r} <= 4'h0;
            tsel_r <= 8'h00;
            {scan_off_r, crc_off_r} <= 2'b00;
            ie_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_scon) begin
                sen_r <= wbyte[crcs_pkg::SCON_EN];
                burst_r <= wbyte[crcs_pkg::SCON_BURST];
                memory_region_select_r <= wbyte[crcs_pkg::SCON_MEMORY_REGION_SELECT];
                scan_trigger_enable_r <= wbyte[crcs_pkg::SCON_TRIG];
            end
            if (wr && idx == crcs_pkg::IDX_TSEL) begin
                tsel_r <= wbyte;
            end
            if (wr && idx == crcs_pkg::IDX_PMD) begin
                crc_off_r <= wbyte[crcs_pkg::PMD_CRC];
                scan_off_r <= wbyte[crcs_pkg::PMD_SCAN];
            end
            if (wr_sstat) begin
                ie_r <= wbyte[crcs_pkg::SSTAT_IE];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slo_r <= '0;
            shi_r <= '0;
        end else if (ce_i) begin
            if (fetch) begin
                slo_r <= slo_r + 1'b1;
            end else if (wr && hit_l) begin
                slo_r <= slo_put[ADDR_W-1:0];
            end
            if (wr && hit_h) begin
                shi_r <= shi_put[ADDR_W-1:0];
            end
        end
    end

    // Done flag set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srun_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce_i) begin
            srun_r <= srun_nxt;
            if (fetch && last) begin
                done_r <= 1'b1;
            end else if (wr_sstat && !wbyte[crcs_pkg::SSTAT_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r <= 1'b0;
            lock_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            req_r <= req_nxt;
            lock_r <= lock_nxt;
            irq_r <= srun_fall & ie_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Engine

    // Engine shifts data_length_field plus one bits
    crcs_engine u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .kill_i(crc_off_r),
        .halt_i(halt),
        .run_i(go_r),
        .load_i(xfer),
        .word_i(data_r),
        .data_length_field_i(data_length_field_r),
        .poly_length_field_i(poly_length_field_r),
        .poly_i(poly_r),
        .augment_i(augment_zeros_bit_r),
        .lsb_first_i(bit_order_select_r),
        .seed_we_i(wr_seed),
        .seed_lane_i(o_off[1:0]),
        .seed_byte_i(wbyte),
        .acc_o(acc_w),
        .shift_o(shift_w),
        .shifting_o(shifting_w)
    );

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign mem_req_o = req_r;
    assign mem_lock_o = lock_r;
    assign mem_region_o = memory_region_select_r;
    assign mem_addr_o = slo_r;
    assign scan_irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wb_cyc_i && wb_stb_i && !ack_r |=> ack_r ##1 !ack_r)
        else $error("wishbone ack not a single cycle after request");

    low_full_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wr_low |=> full_r)
        else $error("low byte write did not mark word pending");

    en_scan_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        !en_r |=> !srun_r)
        else $error("scan run survived enable low");

    last_stop_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        fetch && last |=> !srun_r && done_r && full_r)
        else $error("scan did not stop at high address");

    full_req_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        full_r && !burst_r |=> !mem_req_o)
        else $error("fetch requested while word pending");

    burst_lock_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        scan_act && burst_r |=> mem_req_o && mem_lock_o)
        else $error("burst scan did not request and lock");

    scan_irq_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        srun_r && !srun_nxt |=> scan_irq_o == $past(ie_r))
        else $error("scan interrupt not matching falling run");

    busy_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        con0_v[crcs_pkg::CON0_BUSY] == (full_r || shifting_w))
        else $error("busy bit wrong");

endmodule : crcs_scanner

`default_nettype wire

// [verif/crcs_mem_model.sv]
// Arbiter and memory model that answers scanner requests
`timescale 1ns/100ps
`default_nettype none

module crcs_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [23:0] addr_i,
    input wire logic [3:0] slow_i,
    output logic grant_o,
    output logic [31:0] rdata_o,
    output logic [15:0] n_fetch_o
);
    logic [3:0] cnt_r;

    // Grant after wait; count only grants met by a request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
            grant_o <= 1'b0;
            rdata_o <= 32'h0;
            n_fetch_o <= 16'h0;
        end else if (req_i && !grant_o && cnt_r == slow_i) begin
            cnt_r <= 4'h0;
            grant_o <= 1'b1;
            rdata_o <= {8'h5a, addr_i};
        end else begin
            if (grant_o && req_i) begin
                n_fetch_o <= n_fetch_o + 16'h1;
            end
            cnt_r <= (req_i && !grant_o) ? cnt_r + 4'h1 : 4'h0;
            grant_o <= 1'b0;
            // Stale data must not look valid
            rdata_o <= ~rdata_o;
        end
    end
endmodule : crcs_mem_model

`default_nettype wire

// [verif/crcs_scanner_bench.sv]
// Self-checking bench for the CRC engine and scanner
`timescale 1ns/100ps
`default_nettype none

module crcs_scanner_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd, mdat;
    logic ack, req, lock, region, grant, irq;
    logic [23:0] maddr;
    logic [7:0] trig = 8'h00;
    logic [7:0] q, r;
    logic [3:0] slow = 4'h0;
    logic [15:0] nf, nf0;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int irqs = 0;

    always #10 clk_i = ~clk_i;

    crcs_scanner u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .mem_req_o(req), .mem_lock_o(lock),
        .mem_region_o(region), .mem_addr_o(maddr), .mem_grant_i(grant),
        .mem_rdata_i(mdat), .trig_i(trig), .scanner_fuse_i(1'b1), .scan_irq_o(irq));

    crcs_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .addr_i(maddr),
        .slow_i(slow), .grant_o(grant), .rdata_o(mdat), .n_fetch_o(nf));

    ////////////////////////////////////////
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (n == 64) n_mismatch++;
        q = rd[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [9:0] i, input logic [7:0] e, input string nm);
        bus(1'b0, i, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask : rdchk

    task automatic poll(input logic [9:0] i, input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, i, 8'h00);
            n++;
        end while (q[b] !== v && n < 200);
        chk("poll", 16'(v), 16'(q[b]));
    endtask : poll

    always @(posedge clk_i) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (cycles == 30000) begin
            n_mismatch++;
            conclude();
        end
    end

    ////////////////////////////////////////
    initial begin
        void'($urandom(27));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(crcs_pkg::IDX_CON0, crcs_pkg::CON0_RST, "con0");
        rdchk(10'h3ff, 8'h00, "unmapped");
        r = 8'($urandom) & 8'hfe;
        bus(1'b1, crcs_pkg::IDX_CON0, 8'h88);
        bus(1'b1, crcs_pkg::IDX_OVL, r);
        rdchk(crcs_pkg::IDX_OVL, r | 8'h01, "poly");
        bus(1'b1, crcs_pkg::IDX_CON0, 8'h80);
        bus(1'b1, crcs_pkg::IDX_OVL, r);
        bus(1'b1, crcs_pkg::IDX_CON0, 8'h8c);
        rdchk(crcs_pkg::IDX_OVL, r, "result");
        bus(1'b1, crcs_pkg::IDX_CON2, 8'h1f);
        for (int k = 3; k > 0; k--) bus(1'b1, crcs_pkg::IDX_DATA + 10'(k), 8'($urandom));
        rdchk(crcs_pkg::IDX_CON0, 8'h8c, "no word yet");
        bus(1'b1, crcs_pkg::IDX_DATA, 8'($urandom));
        rdchk(crcs_pkg::IDX_CON0, 8'had, "held");
        bus(1'b1, crcs_pkg::IDX_CON0, 8'hcc);
        poll(crcs_pkg::IDX_CON0, crcs_pkg::CON0_BUSY, 1'b0);
        rdchk(crcs_pkg::IDX_CON0, 8'hcc, "drained");
        bus(1'b1, crcs_pkg::IDX_SSTAT, 8'h02);
        bus(1'b1, crcs_pkg::IDX_SLO, 8'h00);
        bus(1'b1, crcs_pkg::IDX_SHI, 8'h03);
        bus(1'b1, crcs_pkg::IDX_SCON, 8'h90);
        nf0 = nf;
        bus(1'b1, crcs_pkg::IDX_SCON, 8'hd0);
        poll(crcs_pkg::IDX_SCON, crcs_pkg::SCON_RUN, 1'b0);
        poll(crcs_pkg::IDX_CON0, crcs_pkg::CON0_BUSY, 1'b0);
        chk("fetches", 16'h4, nf - nf0);
        rdchk(crcs_pkg::IDX_SSTAT, 8'h03, "done");
        chk("irqs", 16'h1, 16'(irqs));
        chk("region", 16'h1, 16'(region));
        bus(1'b1, crcs_pkg::IDX_SSTAT, 8'h00);
        rdchk(crcs_pkg::IDX_SSTAT, 8'h00, "cleared");
        slow <= 4'h3;
        bus(1'b1, crcs_pkg::IDX_SHI, 8'hff);
        bus(1'b1, crcs_pkg::IDX_SCON, 8'he0);
        repeat (8) @(posedge clk_i);
        chk("lock", 16'h1, 16'(lock));
        bus(1'b1, crcs_pkg::IDX_CON0, 8'h4c);
        rdchk(crcs_pkg::IDX_SCON, 8'ha0, "aborted");
        chk("masked", 16'h1, 16'(irqs));
        slow <= 4'h0;
        bus(1'b1, crcs_pkg::IDX_CON0, 8'hcc);
        bus(1'b1, crcs_pkg::IDX_SLO, 8'h00);
        bus(1'b1, crcs_pkg::IDX_SHI, 8'h01);
        bus(1'b1, crcs_pkg::IDX_TSEL, 8'h02);
        bus(1'b1, crcs_pkg::IDX_SCON, 8'h88);
        bus(1'b1, crcs_pkg::IDX_SCON, 8'hc8);
        nf0 = nf;
        repeat (20) @(posedge clk_i);
        chk("untriggered", nf0, nf);
        trig <= 8'h04;
        poll(crcs_pkg::IDX_SCON, crcs_pkg::SCON_RUN, 1'b0);
        chk("triggered", nf0 + 16'h2, nf);
        conclude();
    end
endmodule : crcs_scanner_bench

`default_nettype wire
